//--- blink_timebase.sv
`timescale 1ns/100ps
`default_nettype none
`include "led_defs.svh"

module blink_timebase #(
	parameter int TICK_CYCLES = `TICK_MS * `CLK_KHZ
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic clk_en,
	output logic      tick,
	output logic      frame_start,
	output logic      blink_fast,
	output logic      blink_slow,
	output logic      blink_vslow,
	output logic      blink_single,
	output logic      blink_double
);
	localparam int FAST  = `FAST_PERIOD_MS / `TICK_MS;
	localparam int SLOW  = `SLOW_PERIOD_MS / `TICK_MS;
	localparam int VSLOW = `VSLOW_PERIOD_MS / `TICK_MS;
	localparam int PULSE = `PULSE_MS / `TICK_MS;
	localparam int GAP   = `GAP_MS / `TICK_MS;
	localparam int WRAP  = `PHASE_WRAP_MS / `TICK_MS;

	logic [31:0] prescale;
	logic [31:0] next_prescale;
	logic [9:0]  phase;
	logic [9:0]  next_phase;
	logic        next_tick;
	int          p;

	////////////////////////////////////////////////////////////////////////////
	// one divider: prescaler to tick, tick counts a phase common to all rates
	always_comb begin
		next_tick = (prescale == 32'(TICK_CYCLES - 1));
		next_prescale = next_tick ? 32'h0000_0000 : prescale + 32'h0000_0001;
		next_phase = phase;
		if (next_tick) begin
			next_phase = (phase == 10'(WRAP - 1)) ? 10'h000 : phase + 10'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prescale <= 32'h0000_0000;
			phase    <= 10'h000;
			tick     <= 1'b0;
		end else if (clk_en) begin
			prescale <= next_prescale;
			phase    <= next_phase;
			tick     <= next_tick;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// patterns decoded from the phase; wrap is a multiple of every period
	always_comb begin
		p = int'(phase);
		frame_start  = (p % FAST) == 0;
		blink_fast   = (p % FAST) < FAST / 2;
		blink_slow   = (p % SLOW) < SLOW / 2;
		blink_vslow  = (p % VSLOW) < VSLOW / 2;
		blink_single = (p % (PULSE + GAP)) < PULSE;
		blink_double = ((p % (3 * PULSE + GAP)) < PULSE) ||
			(((p % (3 * PULSE + GAP)) >= 2 * PULSE) &&
			((p % (3 * PULSE + GAP)) < 3 * PULSE));
	end
endmodule // blink_timebase
`default_nettype wire

//--- led_defs.svh
`ifndef LED_DEFS_SVH
`define LED_DEFS_SVH

// clock and blink timing
`define CLK_KHZ           200000
`define TICK_MS           25
`define FAST_PERIOD_MS    250
`define SLOW_PERIOD_MS    1000
`define VSLOW_PERIOD_MS   2000
`define PULSE_MS          200
`define GAP_MS            1000
`define PHASE_WRAP_MS     24000

// register byte offsets
`define OFF_CTRL          12'h000
`define OFF_WD_INTERVAL   12'h004
`define OFF_STATUS        12'h008
`define OFF_LEDS          12'h00C

// control field positions
`define CTRL_WD_EN        0
`define CTRL_FLASH_CLR    1
`define CTRL_WD_CLR       2

// reset values
`define CTRL_RESET        32'h0000_0000
`define WD_INTERVAL_RESET 16'h0028

`endif

//--- led_observer.sv
`timescale 1ns/100ps
`default_nettype none

module led_observer (
	input wire logic clk,
	input wire logic clr,
	input wire logic led,
	output int       max_on,
	output int       min_off,
	output int       max_off,
	output int       edges
);
	int   run;
	logic last;
	// the eye times lit and dark runs; the run cut by clr is partial, so only runs
	// that began on an edge are kept
	always @(posedge clk) begin
		if (clr) begin
			{run, edges, max_on, min_off, max_off} <= '0;
		end else if (led !== last) begin
			edges <= edges + 1;
			run <= 1;
			if (edges > 0 && last === 1'b1 && run > max_on) max_on <= run;
			if (edges > 0 && last === 1'b0 && run > max_off) max_off <= run;
			if (edges > 0 && last === 1'b0 && (min_off == 0 || run < min_off)) min_off <= run;
		end else begin
			run <= run + 1;
		end
		last <= led;
	end
endmodule // led_observer
`default_nettype wire

//--- led_pkg.sv
package led_pkg;
	typedef enum logic [1:0] {
		ESM_INIT,
		ESM_PREOP,
		ESM_SAFEOP,
		ESM_OP
	} esm_state_t;

	typedef enum logic [1:0] {
		FLASH_NONE,
		FLASH_GOOD,
		FLASH_BAD
	} flash_result_t;
endpackage

//--- status_led_indicator.sv
`timescale 1ns/100ps
`default_nettype none
`include "led_defs.svh"

module status_led_indicator #(
	parameter int NUM_PORTS   = 2,
	parameter int TICK_CYCLES = `TICK_MS * `CLK_KHZ
) (
	input  wire logic                  REF_CLK,
	input  wire logic                  RESET,
	input  wire logic                  CLK_EN,
	input  wire logic                  PSEL,
	input  wire logic                  PENABLE,
	input  wire logic                  PWRITE,
	input  wire logic [11:0]           PADDR,
	input  wire logic [31:0]           PWDATA,
	output logic      [31:0]           PRDATA,
	output logic                       PREADY,
	output logic                       PSLVERR,
	input  wire led_pkg::esm_state_t   FB_STATE,
	input  wire logic                  SYNC_ERR,
	input  wire logic                  SM_WD_TIMEOUT,
	input  wire logic                  LINK_FAULT,
	input  wire logic                  DRV_FAULT,
	input  wire logic                  FLASH_WR_OK,
	input  wire logic                  FLASH_WR_FAIL,
	input  wire logic                  OUT_REFRESH,
	input  wire logic [NUM_PORTS-1:0]  PORT_LINK,
	input  wire logic [NUM_PORTS-1:0]  PORT_ACT,
	output logic                       RUN_LED,
	output logic                       ERR_RED_LED,
	output logic                       ERR_GREEN_LED,
	output logic      [NUM_PORTS-1:0]  ACT_LED,
	output logic                       SAFEOP_REQ
);
	import led_pkg::*;

	logic tick;
	logic frame_start;
	logic blink_fast;
	logic blink_slow;
	logic blink_vslow;
	logic blink_single;
	logic blink_double;

	////////////////////////////////////////////////////////////////////////////
	// shared timebase, all indicators blink in step
	blink_timebase #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timebase (
		.clk          (REF_CLK),
		.reset        (RESET),
		.clk_en       (CLK_EN),
		.tick         (tick),
		.frame_start  (frame_start),
		.blink_fast   (blink_fast),
		.blink_slow   (blink_slow),
		.blink_vslow  (blink_vslow),
		.blink_single (blink_single),
		.blink_double (blink_double)
	);

	////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states while CLK_EN is high, write at access edge, read data latched in setup
	logic        wd_en;
	logic        next_wd_en;
	logic [15:0] wd_interval;
	logic [15:0] next_wd_interval;
	logic [31:0] next_prdata;
	logic        wr_access;
	logic        addr_hit;
	logic        flash_clr;
	logic        wd_clr;
	logic [31:0] status_word;
	logic [31:0] led_word;

	// status and leds read state; widths kept fixed so reads never pad silently
	logic        wd_expired;
	flash_result_t flash_result;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[0]   = wd_expired;
		status_word[1]   = (flash_result == FLASH_GOOD);
		status_word[2]   = (flash_result == FLASH_BAD);
		status_word[3]   = SYNC_ERR;
		status_word[4]   = LINK_FAULT;
		status_word[5]   = DRV_FAULT;
		status_word[7:6] = FB_STATE;
		status_word[8]   = SAFEOP_REQ;
		led_word = 32'h0000_0000;
		led_word[0] = RUN_LED;
		led_word[1] = ERR_RED_LED;
		led_word[2] = ERR_GREEN_LED;
		led_word[3 +: NUM_PORTS] = ACT_LED;
	end

	always_comb begin
		addr_hit = (PADDR == `OFF_CTRL) || (PADDR == `OFF_WD_INTERVAL) ||
			(PADDR == `OFF_STATUS) || (PADDR == `OFF_LEDS);
		PREADY    = CLK_EN; // stall the master while the block is frozen
		PSLVERR   = PSEL && PENABLE && !addr_hit;
		wr_access = PSEL && PENABLE && PWRITE && CLK_EN;
		flash_clr = wr_access && (PADDR == `OFF_CTRL) && PWDATA[`CTRL_FLASH_CLR];
		wd_clr    = wr_access && (PADDR == `OFF_CTRL) && PWDATA[`CTRL_WD_CLR];
		next_wd_en       = wd_en;
		next_wd_interval = wd_interval;
		if (wr_access && (PADDR == `OFF_CTRL)) begin
			next_wd_en = PWDATA[`CTRL_WD_EN];
		end
		if (wr_access && (PADDR == `OFF_WD_INTERVAL)) begin
			next_wd_interval = PWDATA[15:0];
		end
		next_prdata = PRDATA;
		if (PSEL && !PENABLE && !PWRITE) begin
			unique case (PADDR)
				`OFF_CTRL:        next_prdata = {31'h0000_0000, wd_en};
				`OFF_WD_INTERVAL: next_prdata = {16'h0000, wd_interval};
				`OFF_STATUS:      next_prdata = status_word;
				`OFF_LEDS:        next_prdata = led_word;
				default:          next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			wd_en       <= 1'b0;
			wd_interval <= `WD_INTERVAL_RESET;
			PRDATA      <= 32'h0000_0000;
		end else if (CLK_EN) begin
			wd_en       <= next_wd_en;
			wd_interval <= next_wd_interval;
			PRDATA      <= next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output-refresh watchdog in ticks; an expiry sticks until software clears it
	logic [15:0] wd_count;
	logic [15:0] next_wd_count;
	logic        next_wd_expired;

	always_comb begin
		next_wd_count   = wd_count;
		next_wd_expired = wd_expired;
		if (!wd_en || OUT_REFRESH) begin
			next_wd_count = 16'h0000;
		end else if (tick && wd_count != 16'hFFFF) begin
			next_wd_count = wd_count + 16'h0001;
		end
		if (wd_clr) begin
			next_wd_expired = 1'b0;
		end
		// an expiry in the clearing cycle wins over the clear
		if ((wd_en && !OUT_REFRESH && wd_count >= wd_interval) || SM_WD_TIMEOUT) begin
			next_wd_expired = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			wd_count   <= 16'h0000;
			wd_expired <= 1'b0;
		end else if (CLK_EN) begin
			wd_count   <= next_wd_count;
			wd_expired <= next_wd_expired;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// last flash write result, replaced by each new result
	flash_result_t next_flash_result;

	always_comb begin
		next_flash_result = flash_result;
		if (flash_clr) begin
			next_flash_result = FLASH_NONE;
		end
		// a result arriving with the clear is kept; a failure beats a success
		if (FLASH_WR_FAIL) begin
			next_flash_result = FLASH_BAD;
		end else if (FLASH_WR_OK) begin
			next_flash_result = FLASH_GOOD;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			flash_result <= FLASH_NONE;
		end else if (CLK_EN) begin
			flash_result <= next_flash_result;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// run, red and green indicators; red and green are decoded separately
	logic next_run;
	logic next_red;
	logic next_green;
	logic next_safeop;

	always_comb begin
		unique case (FB_STATE)
			ESM_INIT:   next_run = 1'b0;
			ESM_PREOP:  next_run = blink_fast;
			ESM_SAFEOP: next_run = blink_slow;
			ESM_OP:     next_run = 1'b1;
		endcase
		// red: watchdog outranks sync loss, which outranks a link fault
		if (wd_expired) begin
			next_red = blink_double;
		end else if (SYNC_ERR) begin
			next_red = blink_single;
		end else if (LINK_FAULT) begin
			next_red = blink_slow;
		end else begin
			next_red = 1'b0;
		end
		// green never looks at the red decode, so both may light
		if (FB_STATE == ESM_INIT) begin
			next_green = 1'b1;
		end else if (DRV_FAULT) begin
			next_green = blink_vslow;
		end else if (flash_result == FLASH_BAD) begin
			next_green = blink_slow;
		end else if (flash_result == FLASH_GOOD) begin
			next_green = blink_fast;
		end else begin
			next_green = 1'b0;
		end
		next_safeop = wd_expired || LINK_FAULT;
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			RUN_LED       <= 1'b0;
			ERR_RED_LED   <= 1'b0;
			ERR_GREEN_LED <= 1'b0;
			SAFEOP_REQ    <= 1'b0;
		end else if (CLK_EN) begin
			RUN_LED       <= next_run;
			ERR_RED_LED   <= next_red;
			ERR_GREEN_LED <= next_green;
			SAFEOP_REQ    <= next_safeop;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-port link/activity: traffic is held until the next fast period starts so that
	// short bursts still give one visible blink
	for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
		logic act_hold;
		logic next_act_hold;
		logic next_act_led;

		always_comb begin
			next_act_hold = act_hold;
			if (tick && frame_start) begin
				next_act_hold = 1'b0;
			end
			if (PORT_ACT[i]) begin
				next_act_hold = 1'b1;
			end
			next_act_led = PORT_LINK[i] && !(act_hold && !blink_fast);
		end

		always_ff @(posedge REF_CLK) begin
			if (RESET) begin
				act_hold   <= 1'b0;
				ACT_LED[i] <= 1'b0;
			end else if (CLK_EN) begin
				act_hold   <= next_act_hold;
				ACT_LED[i] <= next_act_led;
			end
		end
	end
endmodule // status_led_indicator
`default_nettype wire

//--- status_led_indicator_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "led_defs.svh"

module status_led_indicator_checker #(
	parameter int NUM_PORTS   = 2,
	parameter int TICK_CYCLES = `TICK_MS * `CLK_KHZ
) (
	input wire logic                 REF_CLK,
	input wire logic                 RESET,
	input wire logic                 CLK_EN,
	input wire logic                 PSEL,
	input wire logic                 PENABLE,
	input wire logic [11:0]          PADDR,
	input wire logic                 PREADY,
	input wire logic                 PSLVERR,
	input wire led_pkg::esm_state_t  FB_STATE,
	input wire logic                 SYNC_ERR,
	input wire logic                 LINK_FAULT,
	input wire logic [NUM_PORTS-1:0] PORT_LINK,
	input wire logic                 RUN_LED,
	input wire logic                 ERR_RED_LED,
	input wire logic                 ERR_GREEN_LED,
	input wire logic [NUM_PORTS-1:0] ACT_LED,
	input wire logic                 SAFEOP_REQ
);
	import led_pkg::*;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	////////////////////////////////////////////////////////////////
	// bus answers: zero wait states while CLK_EN is high, error only off the map
	pready_a: assert property (PREADY == CLK_EN) else $error("ready not tied to enable");
	slverr_a: assert property (PSEL && PENABLE |->
		PSLVERR == !(PADDR inside {12'h000, 12'h004, 12'h008, 12'h00C}))
		else $error("slave error wrong");

	////////////////////////////////////////////////////////////////
	// indicators lag their causes by one enabled edge
	run_init_a: assert property ($past(CLK_EN) && $past(FB_STATE) == ESM_INIT |-> !RUN_LED)
		else $error("run lit in init");
	run_steady_a: assert property ($past(CLK_EN) && !$past(RESET) &&
		$past(FB_STATE) == ESM_OP |-> RUN_LED) else $error("run dark in op");
	green_init_a: assert property ($past(CLK_EN) && !$past(RESET) &&
		$past(FB_STATE) == ESM_INIT |-> ERR_GREEN_LED) else $error("green dark in init");
	red_cause_a: assert property (ERR_RED_LED |-> SAFEOP_REQ || $past(SYNC_ERR) || $past(LINK_FAULT))
		else $error("red lit without error");
	link_fallback_a: assert property (!$past(RESET) && $past(LINK_FAULT) |-> SAFEOP_REQ)
		else $error("no fallback on link fault");
	act_link_a: assert property ((ACT_LED & ~$past(PORT_LINK)) == '0)
		else $error("activity lit without link");
	localparam int GAP_CYC = `GAP_MS / `TICK_MS * TICK_CYCLES;
	int sync_dark;

	// dark cycles of red since it fell under a lone sync fault; zero when not timing
	always_ff @(posedge REF_CLK) begin
		if (RESET || ERR_RED_LED || !SYNC_ERR || SAFEOP_REQ) begin
			sync_dark <= 0;
		end else if (sync_dark != 0 || ($fell(ERR_RED_LED) && !$past(SAFEOP_REQ))) begin
			sync_dark <= sync_dark + 1;
		end
	end

	// a single blink must leave a long gap; a short one would be a double blink
	single_gap_a: assert property ($rose(ERR_RED_LED) && sync_dark != 0 && !SAFEOP_REQ |->
		sync_dark >= GAP_CYC) else $error("single blink gap short");
endmodule // status_led_indicator_checker

bind status_led_indicator status_led_indicator_checker #(.NUM_PORTS(NUM_PORTS),
	.TICK_CYCLES(TICK_CYCLES))
	status_led_indicator_checker_inst (.REF_CLK(REF_CLK), .RESET(RESET), .CLK_EN(CLK_EN),
	.PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.FB_STATE(FB_STATE), .SYNC_ERR(SYNC_ERR), .LINK_FAULT(LINK_FAULT), .PORT_LINK(PORT_LINK),
	.RUN_LED(RUN_LED), .ERR_RED_LED(ERR_RED_LED), .ERR_GREEN_LED(ERR_GREEN_LED),
	.ACT_LED(ACT_LED), .SAFEOP_REQ(SAFEOP_REQ));
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s expected %0d seen %0d", n, e, g); end end

module testbench;
	import led_pkg::*;
	localparam int T = 4;
	logic        ref_clk = 0, reset = 1, clr = 0, clk_en = 1;
	logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	esm_state_t  fb_state = ESM_INIT;
	logic        sync_err = 0, wd_to = 0, link_fault = 0, drv_fault = 0;
	logic        fl_ok = 0, fl_fail = 0, refresh = 0, safeop, run_led, red_led, green_led;
	logic [1:0]  port_link = '0, port_act = '0, act_led;
	logic [3:0]  leds;
	int          mon [4], mnf [4], mxf [4], ed [4];
	int          bad_count = 0, comparisons = 0;

	always #2.5 ref_clk = ~ref_clk;
	assign leds = {act_led[0], green_led, red_led, run_led};

	status_led_indicator #(.TICK_CYCLES(T)) status_led_indicator_inst (.REF_CLK(ref_clk),
		.RESET(reset), .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.FB_STATE(fb_state), .SYNC_ERR(sync_err), .SM_WD_TIMEOUT(wd_to),
		.LINK_FAULT(link_fault), .DRV_FAULT(drv_fault), .FLASH_WR_OK(fl_ok),
		.FLASH_WR_FAIL(fl_fail), .OUT_REFRESH(refresh), .PORT_LINK(port_link),
		.PORT_ACT(port_act), .RUN_LED(run_led), .ERR_RED_LED(red_led),
		.ERR_GREEN_LED(green_led), .ACT_LED(act_led), .SAFEOP_REQ(safeop));

	// one eye on each of run, red, green and port 0 activity
	for (genvar g = 0; g < 4; g++) begin : eye
		led_observer led_observer_inst (.clk(ref_clk), .clr(clr), .led(leds[g]),
			.max_on(mon[g]), .min_off(mnf[g]), .max_off(mxf[g]), .edges(ed[g]));
	end

	////////////////////////////////////////////////////////////////
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0; penable <= 0;
		// let an edge pass so a following call never reassigns psel in this step
		@(posedge ref_clk);
	endtask

	// skip three edges while the pattern switches, then watch whole runs
	task watch(int n);
		repeat (3) @(posedge ref_clk);
		clr <= 1;
		@(posedge ref_clk);
		clr <= 0;
		repeat (n) @(posedge ref_clk);
	endtask

	// on = 0 means steady at level f1
	task pat(string n, int i, int on, int f1, int f2);
		if (on == 0) begin `CHK(n, 0, ed[i]) `CHK(n, f1, leds[i]) end
		else begin `CHK(n, on, mon[i]) `CHK(n, f1, mnf[i]) `CHK(n, f2, mxf[i]) end
	endtask

	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] r;
		logic        e;
		int          run_on [4];
		logic        v;
		run_on = '{0, 5 * T, 20 * T, 0};
		repeat (16) @(posedge ref_clk);
		reset <= 0;
		@(posedge ref_clk);
		apb(0, 12'h004, '0, r, e); `CHK("wd interval", 32'h28, r)
		apb(0, 12'h010, '0, r, e); `CHK("unmapped err", 1, e)
		$display("test registers done");
		for (int s = 0; s < 4; s++) begin
			fb_state <= esm_state_t'(s);
			watch(700);
			pat("run", 0, run_on[s], s == 3 ? 1 : run_on[s], run_on[s]);
		end
		$display("test run done");
		fb_state <= ESM_INIT; sync_err <= 1;
		watch(700);
		pat("red single", 1, 8 * T, 40 * T, 40 * T);
		pat("green beside red", 2, 0, 1, 0);
		sync_err <= 0; wd_to <= 1;
		@(posedge ref_clk);
		wd_to <= 0;
		watch(700);
		pat("red double", 1, 8 * T, 8 * T, 40 * T);
		`CHK("safeop", 1, safeop)
		apb(1, 12'h000, 32'h4, r, e);
		link_fault <= 1;
		watch(700);
		pat("red other", 1, 20 * T, 20 * T, 20 * T);
		`CHK("safeop link", 1, safeop)
		link_fault <= 0;
		watch(700);
		pat("red dark", 1, 0, 0, 0);
		$display("test red done");
		apb(1, 12'h004, 32'h2, r, e);
		apb(1, 12'h000, 32'h1, r, e);
		refresh <= 1;
		repeat (100) @(posedge ref_clk);
		`CHK("refreshed", 0, safeop)
		refresh <= 0;
		repeat (40) @(posedge ref_clk);
		`CHK("starved", 1, safeop)
		// a clear while still starved loses to the expiry, so stop the watchdog first
		apb(1, 12'h000, 32'h0, r, e);
		apb(1, 12'h000, 32'h4, r, e);
		apb(0, 12'h008, '0, r, e); `CHK("status cleared", 32'h0, r)
		`CHK("released", 0, safeop)
		$display("test watchdog done");
		fb_state <= ESM_PREOP; drv_fault <= 1; fl_fail <= 1;
		@(posedge ref_clk);
		fl_fail <= 0;
		watch(700);
		pat("green drv", 2, 40 * T, 40 * T, 40 * T);
		drv_fault <= 0;
		watch(700);
		pat("green bad", 2, 20 * T, 20 * T, 20 * T);
		fl_ok <= 1;
		@(posedge ref_clk);
		fl_ok <= 0;
		watch(700);
		pat("green good", 2, 5 * T, 5 * T, 5 * T);
		$display("test green done");
		port_link <= 2'b01;
		watch(200);
		pat("act link", 3, 0, 1, 0);
		port_act <= 2'b11;
		watch(200);
		pat("act traffic", 3, 5 * T, 5 * T, 5 * T);
		`CHK("act no link", 0, act_led[1])
		$display("test activity done");
		// a low enable freezes every pattern and stalls the bus
		clk_en <= 0;
		@(posedge ref_clk);
		v = run_led;
		repeat (30) begin
			@(posedge ref_clk);
			`CHK("frozen run", v, run_led)
		end
		`CHK("frozen ready", 0, pready)
		clk_en <= 1;
		$display("test enable done");
		end_of_test();
	end

	initial begin
		#200000;
		`CHK("timeout", 0, 1)
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
